/* File: design/pcsl_tx_core.sv */
// Transmit path of the coding sublayer: buffering, two-codeword interleave, parity
// generation, symbol distribution over serial lanes, pad generation, loopback and
// degraded symbol-error detection.
// Assumes all inputs come from logic on core_clk and that management sits outside.
// What this block does
// R1: Loopback returns accepted transmit symbols to receive.
// R2: Transmit to lanes continues during loopback.
// R3: Lane receive data ignored during loopback.
// R4: Loopback input mirrors management loopback bit.
// R5: Both-way delay within 200G budget.
// R6: Both-way delay within 400G budget.
// R7: Each lane sends symbol bit 0 first.
// R8: Alternate transmit symbols between two codewords.
// R9: Lanes receive whole 10-bit symbols round-robin.
// R10: Optional degraded error rate against programmed threshold.
// R11: Parity for 544-symbol codewords, 514 message.
// R12: Marker pad bits from ninth-order PRBS.
`timescale 1ns/100ps
`default_nettype none
module pcsl_tx_core
	import pcsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic loopback_en,
	input wire logic [SYM_W-1:0] tx_mii_sym,
	input wire logic tx_mii_valid,
	output logic tx_mii_ready,
	input wire logic [SYM_W-1:0] rx_pma_sym,
	input wire logic rx_pma_valid,
	output logic [SYM_W-1:0] rx_mii_sym,
	output logic rx_mii_valid,
	output logic [LANE_COUNT-1:0] pma_tx_bits,
	output logic pma_tx_valid,
	input wire logic am_pad_req,
	output logic [PAD_W-1:0] am_pad_bits,
	output logic am_pad_valid,
	input wire logic fec_ser_en,
	input wire logic fec_cw_done,
	input wire logic [ERR_W-1:0] fec_cw_sym_err,
	input wire logic [SER_W-1:0] ser_act_thresh,
	input wire logic [SER_W-1:0] ser_deact_thresh,
	input wire logic [SER_W-1:0] ser_interval,
	output logic fec_degraded
);

	logic [SYM_W-1:0] fifo_sym;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_ready;

	pcsl_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.reset_n(reset_n),
		.in_data(tx_mii_sym),
		.in_valid(tx_mii_valid),
		.in_ready(fifo_ready),
		.out_data(fifo_sym),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	assign tx_mii_ready = fifo_ready;

	// Receive side toward the upper interface.
	logic [SYM_W-1:0] rx_sym_q, rx_sym_d;
	logic rx_valid_q, rx_valid_d;

	always_comb begin
		if (loopback_en) begin // [R4]
			rx_sym_d = tx_mii_sym; // [R1] [R3]
			rx_valid_d = tx_mii_valid && fifo_ready; // [R1]
		end else begin
			rx_sym_d = rx_pma_sym;
			rx_valid_d = rx_pma_valid;
		end
	end

	// A single register stage here keeps the round trip far inside either budget.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sym_q <= '0;
			rx_valid_q <= 1'b0;
		end else begin
			rx_sym_q <= rx_sym_d; // [R5] [R6]
			rx_valid_q <= rx_valid_d;
		end
	end

	assign rx_mii_sym = rx_sym_q;
	assign rx_mii_valid = rx_valid_q;

	// Encoder: message symbols pass through, then both parity banks drain interleaved.
	pcsl_state_type state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [SYM_W-1:0] par_q [0:CW_COUNT-1][0:PAR_SYMS-1];
	logic [SYM_W-1:0] par_d [0:CW_COUNT-1][0:PAR_SYMS-1];
	logic [SYM_W-1:0] enc_sym_q, enc_sym_d;
	logic enc_valid_q, enc_valid_d;
	logic bank;
	logic [SYM_W-1:0] fb;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		par_d = par_q;
		enc_sym_d = enc_sym_q;
		enc_valid_d = 1'b0;
		fifo_pop = 1'b0;
		bank = cnt_q[0]; // [R8]
		fb = '0;
		case (state_q)
			ST_MSG: begin
				// The encoder keeps running whatever the loopback setting is.
				if (fifo_valid) begin // [R2]
					fifo_pop = 1'b1;
					fb = fifo_sym ^ par_q[bank][PAR_SYMS-1];
					for (int k = PAR_SYMS - 1; k > 0; k--) begin
						par_d[bank][k] = par_q[bank][k-1] ^ pcsl_gf_mul(fb, GEN[k]); // [R11]
					end
					par_d[bank][0] = pcsl_gf_mul(fb, GEN[0]); // [R11]
					enc_sym_d = fifo_sym;
					enc_valid_d = 1'b1;
					if (cnt_q == MSG_LAST) begin // [R11]
						cnt_d = '0;
						state_d = ST_PAR;
					end else begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
			end
			ST_PAR: begin
				enc_sym_d = par_q[bank][PAR_SYMS-1];
				enc_valid_d = 1'b1;
				for (int k = PAR_SYMS - 1; k > 0; k--) begin
					par_d[bank][k] = par_q[bank][k-1];
				end
				par_d[bank][0] = '0;
				if (cnt_q == PAR_LAST) begin // [R11]
					cnt_d = '0;
					state_d = ST_MSG;
				end else begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			default: begin
				state_d = ST_MSG;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_MSG;
			cnt_q <= '0;
			enc_sym_q <= '0;
			enc_valid_q <= 1'b0;
			for (int b = 0; b < CW_COUNT; b++) begin
				for (int k = 0; k < PAR_SYMS; k++) begin
					par_q[b][k] <= '0;
				end
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			enc_sym_q <= enc_sym_d;
			enc_valid_q <= enc_valid_d;
			par_q <= par_d;
		end
	end

	// Lane distribution: symbol n goes whole to lane n mod LANE_COUNT.
	logic [SLOT_W-1:0] slot_q, slot_d;
	logic tx_valid_q, tx_valid_d;

	always_comb begin
		slot_d = slot_q;
		tx_valid_d = enc_valid_q;
		if (enc_valid_q) begin
			slot_d = (slot_q == SLOT_LAST) ? '0 : slot_q + SLOT_ONE; // [R9]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slot_q <= '0;
			tx_valid_q <= 1'b0;
		end else begin
			slot_q <= slot_d;
			tx_valid_q <= tx_valid_d;
		end
	end

	assign pma_tx_valid = tx_valid_q;

	for (genvar l = 0; l < LANE_COUNT; l++) begin : g_lane
		logic [SYM_W-1:0] sr_q, sr_d;
		logic bit_q, bit_d;

		always_comb begin
			sr_d = sr_q;
			bit_d = bit_q;
			if (enc_valid_q) begin
				if (slot_q == SLOT_W'(l)) begin // [R9]
					bit_d = enc_sym_q[0]; // [R7]
					sr_d = {1'b0, enc_sym_q[SYM_W-1:1]};
				end else begin
					bit_d = sr_q[0]; // [R7]
					sr_d = {1'b0, sr_q[SYM_W-1:1]};
				end
			end
		end

		always_ff @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				sr_q <= '0;
				bit_q <= 1'b0;
			end else begin
				sr_q <= sr_d;
				bit_q <= bit_d;
			end
		end

		assign pma_tx_bits[l] = bit_q;
	end

	// Pad generator: each request takes the next PAD_W sequence bits, oldest in bit 0.
	logic [PRBS_W-1:0] prbs_q, prbs_d;
	logic [PAD_W-1:0] pad_q, pad_d;
	logic pad_valid_q, pad_valid_d;
	logic [PRBS_W-1:0] prbs_t;
	logic prbs_new;

	always_comb begin
		prbs_t = prbs_q;
		prbs_new = 1'b0;
		pad_d = pad_q;
		for (int i = 0; i < PAD_W; i++) begin
			prbs_new = prbs_t[PRBS_TAP_A] ^ prbs_t[PRBS_TAP_B]; // [R12]
			pad_d[i] = prbs_new;
			prbs_t = {prbs_t[PRBS_W-2:0], prbs_new};
		end
		if (am_pad_req) begin
			prbs_d = prbs_t;
		end else begin
			prbs_d = prbs_q;
			pad_d = pad_q;
		end
		pad_valid_d = am_pad_req;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prbs_q <= PRBS_SEED;
			pad_q <= '0;
			pad_valid_q <= 1'b0;
		end else begin
			prbs_q <= prbs_d;
			pad_q <= pad_d;
			pad_valid_q <= pad_valid_d;
		end
	end

	assign am_pad_bits = pad_q;
	assign am_pad_valid = pad_valid_q;

	// Degraded error-rate monitor over an interval of decoded codewords.
	logic [SER_W-1:0] acc_q, acc_d;
	logic [SER_W-1:0] cw_q, cw_d;
	logic deg_q, deg_d;
	logic [SER_W-1:0] total;

	always_comb begin
		acc_d = acc_q;
		cw_d = cw_q;
		deg_d = deg_q;
		total = acc_q + SER_W'(fec_cw_sym_err);
		if (!fec_ser_en) begin
			acc_d = '0;
			cw_d = '0;
			deg_d = 1'b0;
		end else if (fec_cw_done) begin
			if ((cw_q + SER_ONE) >= ser_interval) begin
				if (!deg_q && (total > ser_act_thresh)) begin // [R10]
					deg_d = 1'b1;
				end else if (deg_q && (total <= ser_deact_thresh)) begin // [R10]
					deg_d = 1'b0;
				end
				acc_d = '0;
				cw_d = '0;
			end else begin
				acc_d = total;
				cw_d = cw_q + SER_ONE;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= '0;
			cw_q <= '0;
			deg_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cw_q <= cw_d;
			deg_q <= deg_d;
		end
	end

	assign fec_degraded = deg_q;

endmodule
`default_nettype wire

/* File: design/pcsl_pkg.sv */
// Shared constants, types and Galois-field helpers for the coding sublayer transmit block.
// Assumes 10-bit symbols and a single core clock domain for every user of the package.
package pcsl_pkg;

	localparam int SYM_W = 10;
	localparam int MSG_SYMS = 514;
	localparam int CW_SYMS = 544;
	localparam int PAR_SYMS = CW_SYMS - MSG_SYMS;
	localparam int CW_COUNT = 2;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] MSG_LAST = 11'(MSG_SYMS * CW_COUNT - 1);
	localparam logic [CNT_W-1:0] PAR_LAST = 11'(PAR_SYMS * CW_COUNT - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

	// Field reduction taps below x^10; a fixed package localparam that no user can override.
	localparam logic [SYM_W-1:0] GF_POLY_LOW = 10'h009;
	localparam logic [SYM_W-1:0] GF_ONE = 10'h001;
	localparam logic [SYM_W-1:0] GF_ALPHA = 10'h002;

	localparam int LANE_COUNT = 10;
	localparam int SLOT_W = 4;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 4'h9;
	localparam logic [SLOT_W-1:0] SLOT_ONE = 4'h1;

	localparam int FIFO_W = SYM_W;
	localparam int FIFO_DEPTH = 8;

	localparam int PRBS_W = 9;
	localparam logic [PRBS_W-1:0] PRBS_SEED = 9'h1FF;
	localparam int PRBS_TAP_A = 8;
	localparam int PRBS_TAP_B = 4;
	localparam int PAD_W = 10;

	localparam int SER_W = 32;
	localparam int ERR_W = 5;
	localparam logic [SER_W-1:0] SER_ONE = 32'h00000001;

	// Latency budgets in picoseconds and the resulting longest cycle counts.
	localparam int CLK_PERIOD_PS = 100000;
	localparam int LAT_200_PS = 801280;
	localparam int LAT_400_PS = 800000;
	localparam int LAT_200_CYCLES = LAT_200_PS / CLK_PERIOD_PS;
	localparam int LAT_400_CYCLES = LAT_400_PS / CLK_PERIOD_PS;
	localparam int PATH_DEPTH = 1;

	typedef enum logic [1:0] {
		ST_MSG = 2'b00,
		ST_PAR = 2'b01
	} pcsl_state_type;

	typedef logic [PAR_SYMS:0][SYM_W-1:0] pcsl_gen_type;

	function automatic logic [SYM_W-1:0] pcsl_gf_mul(input logic [SYM_W-1:0] a,
		input logic [SYM_W-1:0] b);
		logic [SYM_W-1:0] r;
		r = '0;
		for (int i = SYM_W - 1; i >= 0; i--) begin
			r = {r[SYM_W-2:0], 1'b0} ^ (r[SYM_W-1] ? GF_POLY_LOW : '0);
			if (b[i]) begin
				r = r ^ a;
			end
		end
		return r;
	endfunction

	// Builds the product of (x + alpha^i) for every parity root.
	function automatic pcsl_gen_type pcsl_gen_poly();
		pcsl_gen_type g;
		logic [SYM_W-1:0] root;
		g = '0;
		g[0] = GF_ONE;
		root = GF_ONE;
		for (int i = 0; i < PAR_SYMS; i++) begin
			for (int k = PAR_SYMS; k > 0; k--) begin
				g[k] = g[k-1] ^ pcsl_gf_mul(g[k], root);
			end
			g[0] = pcsl_gf_mul(g[0], root);
			root = pcsl_gf_mul(root, GF_ALPHA);
		end
		return g;
	endfunction

	localparam pcsl_gen_type GEN = pcsl_gen_poly();

endpackage

/* File: design/pcsl_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; the reader may stall indefinitely and the writer must honour in_ready.
`timescale 1ns/100ps
`default_nettype none
module pcsl_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	logic push, pop;

	always_comb begin
		push = in_valid && ready_q;
		pop = out_ready && (cnt_q != '0);
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + PTR_ONE;
		end
		if (pop) begin
			rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + PTR_ONE;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + CNT_ONE;
		end else if (pop && !push) begin
			cnt_d = cnt_q - CNT_ONE;
		end
		ready_d = (cnt_d != FULL_CNT);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end

	// Storage carries no reset; only written entries are ever read.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	assign in_ready = ready_q;
	assign out_data = mem[rd_q];
	assign out_valid = (cnt_q != '0);

endmodule
`default_nettype wire

/* File: tb/pcsl_tx_props.sv */
// Checker for the coding sublayer transmit block, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pcsl_tx_props
	import pcsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic loopback_en,
	input wire logic [SYM_W-1:0] tx_mii_sym,
	input wire logic tx_mii_valid,
	input wire logic tx_mii_ready,
	input wire logic [SYM_W-1:0] rx_pma_sym,
	input wire logic rx_pma_valid,
	input wire logic [SYM_W-1:0] rx_mii_sym,
	input wire logic rx_mii_valid,
	input wire logic pma_tx_valid,
	input wire logic am_pad_req,
	input wire logic am_pad_valid,
	input wire logic fec_ser_en,
	input wire logic fec_cw_done,
	input wire logic fec_degraded
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_loop_echo: assert property (loopback_en && tx_mii_valid && tx_mii_ready |=>
		rx_mii_valid && rx_mii_sym == $past(tx_mii_sym)) else $error("no loopback echo");
	a_loop_quiet: assert property (loopback_en && !(tx_mii_valid && tx_mii_ready) |=>
		!rx_mii_valid) else $error("lower side leaked in loopback");
	a_rx_pass: assert property (!loopback_en && rx_pma_valid |=>
		rx_mii_valid && rx_mii_sym == $past(rx_pma_sym)) else $error("receive word late");
	a_tx_onward: assert property (tx_mii_valid && tx_mii_ready |->
		##[1:200] pma_tx_valid) else $error("symbol not sent to lanes");
	a_pad_answer: assert property (am_pad_req |=> am_pad_valid)
		else $error("pad request unanswered");
	a_pad_unasked: assert property (!am_pad_req |=> !am_pad_valid)
		else $error("pad valid without request");
	a_ser_off: assert property (!fec_ser_en |=> !fec_degraded)
		else $error("degraded while monitor off");
	a_ser_hold: assert property (fec_ser_en && !fec_cw_done |=> $stable(fec_degraded))
		else $error("degraded moved without codeword");
endmodule
bind pcsl_tx_core pcsl_tx_props pcsl_tx_props_i (.core_clk, .reset_n, .loopback_en,
	.tx_mii_sym, .tx_mii_valid, .tx_mii_ready, .rx_pma_sym, .rx_pma_valid, .rx_mii_sym,
	.rx_mii_valid, .pma_tx_valid, .am_pad_req, .am_pad_valid, .fec_ser_en, .fec_cw_done,
	.fec_degraded);
`default_nettype wire

/* File: tb/pcsl_pma_model.sv */
// Lower-side source that keeps offering receive words on every other cycle.
// Assumes one clock; the block must filter these words itself.
`timescale 1ns/100ps
`default_nettype none
module pcsl_pma_model
	import pcsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	output logic [SYM_W-1:0] rx_pma_sym,
	output logic rx_pma_valid
);
	logic [SYM_W-1:0] cnt_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 10'h000;
		end else begin
			cnt_q <= cnt_q + 10'h00D;
		end
	end
	// Gap cycles carry inverted bits so that stale data is never mistaken for a word.
	assign rx_pma_valid = cnt_q[0];
	assign rx_pma_sym = cnt_q[0] ? cnt_q : ~cnt_q;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the coding sublayer transmit block.
// Assumes the package, the block, the lower-side model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin fail_count++; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module tb_top
	import pcsl_pkg::*;
;
	logic core_clk = 1'b0, reset_n = 1'b0, loopback_en = 1'b0, tx_mii_valid = 1'b0;
	logic am_pad_req = 1'b0, fec_ser_en = 1'b0, fec_cw_done = 1'b0;
	logic [SYM_W-1:0] tx_mii_sym = 10'h000;
	logic [ERR_W-1:0] fec_cw_sym_err = 5'h00;
	logic [SER_W-1:0] ser_act_thresh = 32'h00000005, ser_deact_thresh = 32'h00000002;
	logic [SER_W-1:0] ser_interval = 32'h00000002;
	logic tx_mii_ready, rx_pma_valid, rx_mii_valid, pma_tx_valid, am_pad_valid, fec_degraded;
	logic [SYM_W-1:0] rx_pma_sym, rx_mii_sym;
	logic [LANE_COUNT-1:0] pma_tx_bits;
	logic [PAD_W-1:0] am_pad_bits;
	int fail_count = 0, samples_checked = 0, vcnt = 0, stalls = 0;
	logic [SYM_W-1:0] enc [0:1199];
	logic [LANE_COUNT-1:0] lane [0:1199];
	logic p_rst, p_loop, p_acc, p_pv;
	logic [SYM_W-1:0] p_tx, p_pma;
	logic [PRBS_W-1:0] prbs = PRBS_SEED;

	pcsl_tx_core pcsl_tx_core_i (.core_clk, .reset_n, .loopback_en, .tx_mii_sym, .tx_mii_valid,
		.tx_mii_ready, .rx_pma_sym, .rx_pma_valid, .rx_mii_sym, .rx_mii_valid, .pma_tx_bits,
		.pma_tx_valid, .am_pad_req, .am_pad_bits, .am_pad_valid, .fec_ser_en, .fec_cw_done,
		.fec_cw_sym_err, .ser_act_thresh, .ser_deact_thresh, .ser_interval, .fec_degraded);
	pcsl_pma_model pcsl_pma_model_i (.core_clk, .reset_n, .rx_pma_sym, .rx_pma_valid);

	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// Receive reference model and lane capture, sampled where outputs have settled.
	always @(negedge core_clk) begin
		if (reset_n && p_rst) begin
			`CHK("rx valid", p_loop ? p_acc : p_pv, rx_mii_valid)
			if (p_loop ? p_acc : p_pv) `CHK("rx sym", p_loop ? p_tx : p_pma, rx_mii_sym)
		end
		if (pma_tx_valid === 1'b1 && vcnt < 1200) begin
			lane[vcnt] = pma_tx_bits;
			vcnt++;
		end
		p_rst = reset_n;
		p_loop = loopback_en;
		p_acc = tx_mii_valid & tx_mii_ready;
		p_pv = rx_pma_valid;
		p_tx = tx_mii_sym;
		p_pma = rx_pma_sym;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic hang(input string w);
		fail_count++;
		$display("BAD %s expected done seen timeout", w);
		report_and_stop();
	endtask

	task automatic send(input logic [SYM_W-1:0] s);
		int n;
		@(posedge core_clk);
		tx_mii_sym <= s;
		tx_mii_valid <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(negedge core_clk);
			if (tx_mii_ready === 1'b1) break;
			stalls++;
		end
		if (n == 300) hang("tx ready");
	endtask

	task automatic idle();
		@(posedge core_clk);
		tx_mii_valid <= 1'b0;
	endtask

	task automatic wait_v(input int target);
		for (int n = 0; n < 2000 && vcnt < target; n++) @(negedge core_clk);
		if (vcnt < target) hang("lane valid");
	endtask

	task automatic t_pad();
		logic [PAD_W-1:0] e;
		@(posedge core_clk);
		am_pad_req <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			if (i == 2) am_pad_req <= 1'b0;
			for (int b = 0; b < PAD_W; b++) begin
				e[b] = prbs[8] ^ prbs[4];
				prbs = {prbs[7:0], e[b]};
			end
			@(negedge core_clk);
			`CHK("pad valid", 1'b1, am_pad_valid)
			`CHK("pad bits", e, am_pad_bits)
		end
		@(negedge core_clk);
		`CHK("pad idle", 1'b0, am_pad_valid)
		$display("test pad done");
	endtask

	// Field product over the package's reduction polynomial, kept apart from the block.
	function automatic logic [SYM_W-1:0] gmul(input logic [SYM_W-1:0] a,
		input logic [SYM_W-1:0] b);
		logic [SYM_W-1:0] r;
		r = 10'h000;
		for (int i = SYM_W - 1; i >= 0; i--) begin
			r = {r[SYM_W-2:0], 1'b0} ^ (r[SYM_W-1] ? GF_POLY_LOW : 10'h000);
			if (b[i]) r = r ^ a;
		end
		return r;
	endfunction

	// Each interleaved codeword rebuilt from the lanes must vanish at every generator root.
	// Ten extra symbols arrive during the parity phase, so the buffer fills and refuses some.
	task automatic t_codeword();
		int n;
		logic [SYM_W-1:0] root, s, bad;
		for (int i = 0; i < MSG_SYMS * CW_COUNT + 10; i++) begin
			enc[i] = (i < MSG_SYMS * CW_COUNT) ? 10'(i * 37 + 5) : 10'h000;
			send(enc[i]);
		end
		idle();
		wait_v(CW_SYMS * CW_COUNT + 10);
		repeat (20) @(negedge core_clk);
		`CHK("codeword length", CW_SYMS * CW_COUNT + 10, vcnt)
		`CHK("ready dropped", 1'b1, stalls > 0)
		for (int t = 0; t < CW_SYMS * CW_COUNT; t++) begin
			for (int d = 0; d < SYM_W; d++) s[d] = lane[t + d][t % 10];
			if (t < MSG_SYMS * CW_COUNT) `CHK("message sym", enc[t], s)
			enc[t] = s;
		end
		for (int a = 0; a < CW_COUNT; a++) begin
			bad = 10'h000;
			root = GF_ONE;
			for (int j = 0; j < PAR_SYMS; j++) begin
				s = 10'h000;
				for (int i = 0; i < CW_SYMS; i++) begin
					if (i < MSG_SYMS) n = CW_COUNT * i + a;
					else n = MSG_SYMS * CW_COUNT + CW_COUNT * (i - MSG_SYMS) + a;
					s = gmul(s, root) ^ enc[n];
				end
				bad = bad | s;
				root = gmul(root, GF_ALPHA);
			end
			`CHK("syndrome", 10'h000, bad)
		end
		$display("test codeword done");
	endtask

	task automatic t_loop_lanes();
		int b, d;
		b = vcnt;
		@(posedge core_clk);
		loopback_en <= 1'b1;
		for (int i = 0; i < 30; i++) begin
			enc[b + i] = 10'(i * 199) ^ 10'h155;
			send(enc[b + i]);
		end
		idle();
		wait_v(b + 30);
		for (int t = b; t < b + 30; t++) begin
			for (int k = 0; k < LANE_COUNT; k++) begin
				d = (t - k) % 10;
				`CHK("lane bit", enc[t - d][d], lane[t][k])
			end
		end
		@(posedge core_clk);
		loopback_en <= 1'b0;
		$display("test loopback lanes done");
	endtask

	task automatic cw(input logic [ERR_W-1:0] e, input logic x);
		@(posedge core_clk);
		fec_cw_done <= 1'b1;
		fec_cw_sym_err <= e;
		@(posedge core_clk);
		fec_cw_done <= 1'b0;
		@(negedge core_clk);
		`CHK("degraded", x, fec_degraded)
	endtask

	task automatic t_ser();
		@(posedge core_clk);
		fec_ser_en <= 1'b1;
		cw(5'h03, 1'b0);
		cw(5'h03, 1'b1);
		cw(5'h01, 1'b1);
		cw(5'h01, 1'b0);
		cw(5'h02, 1'b0);
		cw(5'h03, 1'b0);
		cw(5'h03, 1'b0);
		cw(5'h03, 1'b1);
		@(posedge core_clk);
		fec_ser_en <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK("degraded off", 1'b0, fec_degraded)
		$display("test degraded done");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		t_pad();
		t_codeword();
		t_loop_lanes();
		t_ser();
		report_and_stop();
	end
endmodule
`default_nettype wire
